// File: design/suprw_edge.sv
`timescale 1ns/1ps
// Detects external timebase edges; one-cycle tick per rising edge
module suprw_edge (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic level_i,
  output logic rise_o,
  output logic fall_o
);
  logic last_reg;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_reg <= 1'b0;
    end else begin
      last_reg <= level_i;
    end
  end

  assign rise_o = level_i & ~last_reg;
  assign fall_o = ~level_i & last_reg;
endmodule : suprw_edge

// File: design/suprw_sync.sv
`timescale 1ns/1ps
// Two-flop level synchroniser; first stage feeds only the second
module suprw_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  input wire logic [WIDTH-1:0] rst_val_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic init_reg;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
      init_reg <= 1'b0;
    end else begin
      init_reg <= 1'b1;
      meta_reg <= async_i;
      sync_reg <= init_reg ? meta_reg : rst_val_i;
    end
  end

  assign sync_o = sync_reg;
endmodule : suprw_sync

// File: design/suprw_top.sv
`timescale 1ns/1ps
module suprw_top #(
  parameter int unsigned RESET_TIMEOUT_CYC = suprw_pkg::RESET_TIMEOUT_CYC,
  parameter int unsigned WD_SLOW_CYC = suprw_pkg::WD_SLOW_CYC,
  parameter int unsigned WD_FAST_CYC = suprw_pkg::WD_FAST_CYC,
  parameter int unsigned CE_HOLD_CYC = suprw_pkg::CE_HOLD_CYC,
  parameter int unsigned EXT_WD_NORMAL_CLKS = suprw_pkg::EXT_WD_NORMAL_CLKS,
  parameter int unsigned EXT_WD_FIRST_CLKS = suprw_pkg::EXT_WD_FIRST_CLKS,
  parameter int unsigned EXT_RESET_CLKS = suprw_pkg::EXT_RESET_CLKS
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic supply_low_i,
  input wire logic backup_below_i,
  input wire logic watchdog_kick_input_i,
  input wire logic watchdog_kick_float_i,
  input wire logic timebase_source_select_i,
  input wire logic timebase_input_i,
  input wire logic early_warning_input_i,
  input wire logic chip_sel_n_i,
  output logic reset_n_o,
  output logic reset_hi_o,
  output logic reset_hi_oe_o,
  output logic watchdog_fault_output_n_o,
  output logic backup_on_o,
  output logic supply_ok_o,
  output logic early_warning_flag_n_o,
  output logic chip_sel_n_o
);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (RESET_TIMEOUT_CYC < 1 || WD_SLOW_CYC < 1 || WD_FAST_CYC < 1 || CE_HOLD_CYC < 1 ||
      EXT_WD_NORMAL_CLKS < 1 || EXT_WD_FIRST_CLKS < 1 || EXT_RESET_CLKS < 1) begin : g_chk
    $error("suprw_top: every count must be at least one");
  end

  localparam int unsigned W = suprw_pkg::CNT_W;

  typedef enum logic [2:0] {
    SUPRW_POR = 3'b001,
    SUPRW_RUN = 3'b010,
    SUPRW_PULSE = 3'b100
  } suprw_state_t;

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  logic [5:0] raw_in;
  logic [5:0] syn_in;
  logic uv_s;
  logic bk_s;
  logic kick_s;
  logic float_s;
  logic tsel_s;
  logic tbi_s;

  assign raw_in = {timebase_input_i, timebase_source_select_i, watchdog_kick_float_i,
                   watchdog_kick_input_i, backup_below_i, supply_low_i};

  suprw_sync #(.WIDTH(6)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(raw_in),
    .rst_val_i(6'h03), // Undervoltage assumed until inputs settle
    .sync_o(syn_in)
  );

  assign uv_s = syn_in[0];
  assign bk_s = syn_in[1] & syn_in[0];
  assign kick_s = syn_in[2];
  assign float_s = syn_in[3];
  assign tsel_s = syn_in[4];
  assign tbi_s = syn_in[5];

  // ----------------------------------------
  // Timebase selection
  // ----------------------------------------
  logic ext_tick;
  logic ext_mode;
  logic tick;

  suprw_edge u_tb_edge (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .level_i(tbi_s),
    .rise_o(ext_tick),
    .fall_o()
  );

  // Timebase inputs are ignored in backup mode
  assign ext_mode = ~tsel_s & ~bk_s;
  assign tick = ext_mode ? ext_tick : 1'b1;

  function automatic logic [W-1:0] wd_limit(input logic ext, input logic tb_low,
                                            input logic first);
    logic [W-1:0] r;
    r = W'(WD_SLOW_CYC);
    if (ext) begin
      r = first ? W'(EXT_WD_FIRST_CLKS) : W'(EXT_WD_NORMAL_CLKS);
    end else if (tb_low && !first) begin
      r = W'(WD_FAST_CYC);
    end
    return r;
  endfunction : wd_limit

  logic [W-1:0] rst_limit;
  assign rst_limit = ext_mode ? W'(EXT_RESET_CLKS) : W'(RESET_TIMEOUT_CYC);

  // ----------------------------------------
  // Kick edge detect
  // ----------------------------------------
  logic kick_last_reg;
  logic kick_edge;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      kick_last_reg <= 1'b0;
    end else begin
      kick_last_reg <= kick_s;
    end
  end

  // Pulses of one sample or more show as two edges, either restarts the timer
  assign kick_edge = (kick_s ^ kick_last_reg) & ~float_s;

  // ----------------------------------------
  // Reset sequencer
  // ----------------------------------------
  suprw_state_t state_reg;
  logic [W-1:0] rst_cnt_reg;
  logic [W-1:0] wd_cnt_reg;
  logic first_reg;
  logic wd_off;
  logic wd_expire;
  logic rst_done;

  // Backup requires undervoltage, so it adds nothing to reset here
  assign wd_off = uv_s | bk_s | float_s;
  assign wd_expire = (state_reg == SUPRW_RUN) && !wd_off && tick &&
                     (wd_cnt_reg + 1'b1 >= wd_limit(ext_mode, ~tbi_s, first_reg));
  assign rst_done = tick && (rst_cnt_reg + 1'b1 >= rst_limit);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= SUPRW_POR;
    end else if (uv_s) begin
      state_reg <= SUPRW_POR;
    end else begin
      unique case (state_reg)
        SUPRW_POR, SUPRW_PULSE: begin
          if (rst_done) begin
            state_reg <= SUPRW_RUN;
          end
        end
        SUPRW_RUN: begin
          if (wd_expire) begin
            state_reg <= SUPRW_PULSE;
          end
        end
        default: begin
          state_reg <= SUPRW_POR;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_cnt_reg <= '0;
    end else if (uv_s || state_reg == SUPRW_RUN) begin
      rst_cnt_reg <= '0;
    end else if (tick) begin
      rst_cnt_reg <= rst_done ? '0 : rst_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wd_cnt_reg <= '0;
    end else if (state_reg != SUPRW_RUN || wd_off || kick_edge || wd_expire) begin
      wd_cnt_reg <= '0;
    end else if (tick) begin
      wd_cnt_reg <= wd_cnt_reg + 1'b1;
    end
  end

  // First period after any reset uses the long timeout
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_reg <= 1'b1;
    end else if (state_reg != SUPRW_RUN) begin
      first_reg <= 1'b1;
    end else if (kick_edge) begin
      first_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Watchdog fault output
  // ----------------------------------------
  logic fault_reg;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_reg <= 1'b0;
    end else if (wd_off || kick_edge) begin
      fault_reg <= 1'b0;
    end else if (wd_expire) begin
      fault_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Reset outputs
  // ----------------------------------------
  logic rst_act;
  logic rst_act_reg;
  assign rst_act = (state_reg != SUPRW_RUN);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_act_reg <= 1'b1;
    end else begin
      rst_act_reg <= rst_act;
    end
  end

  // Open-drain high output: release when asserted, external pull defines level
  assign reset_n_o = ~rst_act_reg;
  assign reset_hi_o = 1'b0;
  assign reset_hi_oe_o = ~rst_act_reg;

  // ----------------------------------------
  // Chip-select gating
  // ----------------------------------------
  logic pass_reg;
  logic [W-1:0] ce_cnt_reg;
  logic cs_out_reg;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pass_reg <= 1'b0;
      ce_cnt_reg <= '0;
    end else if (!rst_act) begin
      pass_reg <= 1'b1;
      ce_cnt_reg <= '0;
    end else if (pass_reg) begin
      // Let an active cycle finish, cutting it only once CE_HOLD_CYC cycles have passed
      if (chip_sel_n_i || ce_cnt_reg + 1'b1 >= W'(CE_HOLD_CYC)) begin
        pass_reg <= 1'b0;
      end
      ce_cnt_reg <= ce_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_out_reg <= 1'b1;
    end else begin
      cs_out_reg <= (pass_reg && !(rst_act && chip_sel_n_i)) ? chip_sel_n_i : 1'b1;
    end
  end

  assign chip_sel_n_o = cs_out_reg;

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  logic ew_reg;
  logic fault_n_reg;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ew_reg <= 1'b0;
      fault_n_reg <= 1'b1;
    end else begin
      ew_reg <= early_warning_input_i;
      fault_n_reg <= ~fault_reg;
    end
  end

  assign watchdog_fault_output_n_o = fault_n_reg;
  assign supply_ok_o = ~uv_s;
  assign backup_on_o = bk_s;
  assign early_warning_flag_n_o = ew_reg;
endmodule : suprw_top

// File: include/suprw_pkg.sv
package suprw_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RESET_TIMEOUT_MS = 200;
  localparam int unsigned WD_SLOW_MS = 1600;
  localparam int unsigned WD_FAST_MS = 100;
  localparam int unsigned CE_HOLD_US = 15;
  localparam int unsigned KICK_PULSE_NS = 100;
  localparam int unsigned RESET_TIMEOUT_CYC = RESET_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned WD_SLOW_CYC = WD_SLOW_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned WD_FAST_CYC = WD_FAST_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned CE_HOLD_CYC = CE_HOLD_US * 1000 / CLK_PERIOD_NS;
  // Least pulse width, rounded up
  localparam int unsigned KICK_PULSE_CYC = (KICK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EXT_WD_NORMAL_CLKS = 1024;
  localparam int unsigned EXT_WD_FIRST_CLKS = 4096;
  localparam int unsigned EXT_RESET_CLKS = 2048;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned SYNC_STAGES = 2;
endpackage : suprw_pkg

// File: tb/suprw_checker.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the supervisor
// ----------------------------------------
module suprw_checker #(
  parameter int unsigned CE_HOLD_CYC = 5
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic supply_low_i,
  input wire logic backup_below_i,
  input wire logic early_warning_input_i,
  input wire logic chip_sel_n_i,
  input wire logic reset_n_o,
  input wire logic reset_hi_o,
  input wire logic reset_hi_oe_o,
  input wire logic watchdog_fault_output_n_o,
  input wire logic backup_on_o,
  input wire logic supply_ok_o,
  input wire logic early_warning_flag_n_o,
  input wire logic chip_sel_n_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [7:0] lo_cnt;
  // Saturates so a long reset never wraps back into the hold window
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lo_cnt <= 8'h00;
    end else if (reset_n_o) begin
      lo_cnt <= 8'h00;
    end else if (lo_cnt != 8'hFF) begin
      lo_cnt <= lo_cnt + 8'h01;
    end
  end
  sequence s_uv; supply_low_i [*5]; endsequence
  sequence s_recover; $fell(supply_low_i) ##1 !supply_low_i [*8]; endsequence
  // Open-drain pin is driven low only while reset is released
  property p_pair; reset_hi_oe_o == reset_n_o && !reset_hi_o; endproperty
  property p_uv; s_uv |-> !reset_n_o; endproperty
  property p_recover; s_recover |-> !reset_n_o; endproperty
  property p_wd_off; s_uv |-> watchdog_fault_output_n_o; endproperty
  property p_low_flag; s_uv |-> !supply_ok_o; endproperty
  property p_backup; (supply_low_i && backup_below_i) [*5] |-> backup_on_o; endproperty
  property p_fault_rst; $fell(watchdog_fault_output_n_o) |-> ##[0:2] !reset_n_o; endproperty
  property p_ce_pass; !chip_sel_n_o |-> !$past(chip_sel_n_i); endproperty
  property p_ce_cut; lo_cnt > CE_HOLD_CYC + 2 |-> chip_sel_n_o; endproperty
  property p_warn; early_warning_input_i [*2] |-> early_warning_flag_n_o; endproperty
  a_pair: assert property (p_pair) else $error("reset pair mismatch");
  a_uv: assert property (p_uv) else $error("reset not asserted");
  a_recover: assert property (p_recover) else $error("reset not stretched");
  a_wd_off: assert property (p_wd_off) else $error("fault while supply low");
  a_low_flag: assert property (p_low_flag) else $error("supply flag high");
  a_backup: assert property (p_backup) else $error("backup flag low");
  a_fault_rst: assert property (p_fault_rst) else $error("fault without reset");
  a_ce_pass: assert property (p_ce_pass) else $error("select without input");
  a_ce_cut: assert property (p_ce_cut) else $error("select not cut");
  a_warn: assert property (p_warn) else $error("warning flag low");
endmodule : suprw_checker
bind suprw_top suprw_checker #(.CE_HOLD_CYC(CE_HOLD_CYC)) suprw_checker_inst (.*);

// File: tb/suprw_proc_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Processor on the far side
// ----------------------------------------
module suprw_proc_model (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic kick_en_i,
  input wire logic cs_req_i,
  output logic kick_o,
  output logic chip_sel_n_o
);
  logic [1:0] gap = 2'h0;
  initial kick_o = 1'b0;
  initial chip_sel_n_o = 1'b1;
  // A processor held in reset runs no code, so it cannot kick
  always @(negedge core_clk_i) begin
    gap <= gap + 2'h1;
    if (kick_en_i && reset_n_i && gap == 2'h3) begin
      kick_o <= ~kick_o;
    end
    chip_sel_n_o <= ~cs_req_i;
  end
endmodule : suprw_proc_model

// File: tb/suprw_top_tb.sv
`timescale 1ns/1ps
// ----------------------------------------
// Supervisor testbench
// ----------------------------------------
module suprw_top_tb;
  localparam int RT = 20;
  localparam int WS = 160;
  logic clk = 1'b0, rst_n = 1'b0, sl = 1'b0, bb = 1'b0, fl = 1'b0, sel = 1'b1;
  logic lvl = 1'b1, ext = 1'b0, osc = 1'b0, pf = 1'b1, ken = 1'b1, csr = 1'b1;
  logic kick, cs_in, r_n, r_hi, r_oe, wdo_n, bk, ok, pf_n, cs_o;
  int fails = 0;
  int checks_done = 0;
  initial forever #5 clk = ~clk;
  always #40 osc = ext ? ~osc : 1'b0;
  suprw_top #(.RESET_TIMEOUT_CYC(RT), .WD_SLOW_CYC(WS), .WD_FAST_CYC(10), .CE_HOLD_CYC(5),
    .EXT_WD_NORMAL_CLKS(8), .EXT_WD_FIRST_CLKS(32), .EXT_RESET_CLKS(16)) suprw_top_inst (
    .core_clk_i(clk), .rst_n_i(rst_n), .supply_low_i(sl), .backup_below_i(bb),
    .watchdog_kick_input_i(kick), .watchdog_kick_float_i(fl), .timebase_source_select_i(sel),
    .timebase_input_i(ext ? osc : lvl), .early_warning_input_i(pf), .chip_sel_n_i(cs_in),
    .reset_n_o(r_n), .reset_hi_o(r_hi), .reset_hi_oe_o(r_oe), .watchdog_fault_output_n_o(wdo_n),
    .backup_on_o(bk), .supply_ok_o(ok), .early_warning_flag_n_o(pf_n), .chip_sel_n_o(cs_o));
  suprw_proc_model suprw_proc_model_inst (.core_clk_i(clk), .reset_n_i(r_n), .kick_en_i(ken),
    .cs_req_i(csr), .kick_o(kick), .chip_sel_n_o(cs_in));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  task automatic wt(input bit on_wdo, input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while ((on_wdo ? wdo_n : r_n) !== v && n < 4000) begin
      cyc(1);
      n++;
    end
    chk(n >= lo && n <= hi, 1'b1);
  endtask : wt
  task automatic t_powerup;
    cyc(3);
    chk(cs_o, 1'b1);
    wt(1'b0, 1'b1, RT - 3, RT + 6);
    cyc(2);
    chk(cs_o, 1'b0);
    chk({r_oe, r_hi}, 2'h2);
    $display("powerup test done");
  endtask : t_powerup
  task automatic t_uv;
    sl = 1'b1;
    bb = 1'b1;
    pf = 1'b0;
    cyc(4);
    chk({r_n, r_oe, r_hi}, 3'h0);
    chk({ok, bk, wdo_n, pf_n}, 4'h6);
    chk(cs_o, 1'b0);
    pf = 1'b1;
    cyc(7);
    chk(cs_o, 1'b1);
    bb = 1'b0;
    sl = 1'b0;
    cyc(4);
    chk({ok, bk, r_n}, 3'h4);
    wt(1'b0, 1'b1, RT - 4, RT + 4);
    $display("undervoltage test done");
  endtask : t_uv
  task automatic t_wd(input logic ts, input logic tl, input int first, input int per, input int rst);
    sel = ts;
    lvl = tl;
    ext = ~ts;
    cyc(first);
    ken = 1'b0;
    wt(1'b1, 1'b0, per - 6, per + 20);
    cyc(2);
    chk(r_n, 1'b0);
    wt(1'b0, 1'b1, rst - 6, rst + 12);
    chk(wdo_n, 1'b0);
    wt(1'b0, 1'b0, 0, (ts ? WS : 256) + 20);
    wt(1'b0, 1'b1, rst - 6, rst + 12);
    ken = 1'b1;
    cyc(8);
    chk(wdo_n, 1'b1);
    $display("watchdog test done");
  endtask : t_wd
  task automatic t_float;
    fl = 1'b1;
    ken = 1'b0;
    cyc(WS + 40);
    chk({wdo_n, r_n}, 2'h3);
    fl = 1'b0;
    ken = 1'b1;
    cyc(8);
    $display("floating test done");
  endtask : t_float
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #300000;
    fails++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_powerup();
    t_uv();
    t_wd(1'b1, 1'b1, 20, WS, RT);
    t_wd(1'b1, 1'b0, 20, 10, RT);
    t_wd(1'b0, 1'b0, 300, 64, 128);
    sel = 1'b1;
    ext = 1'b0;
    lvl = 1'b1;
    t_float();
    end_of_test();
  end
endmodule : suprw_top_tb
